// File: tb_tpc_core.sv
// Self-checking bench for the transmit payload conditioning block.
// Assumes the backplane model tpc_bp; the bench plays the line side and the pattern unit.
module tb_tpc_core
	import tpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ordy = 1'b1;
	logic [8:0] adr = '0;
	logic [31:0] wdat = '0, rdat;
	logic ack, inv, inr, ov, take, detv, d7, ins, gi, gv;
	tpc_item_t item;
	logic [7:0] alaw = 8'h11, mulaw = 8'h22, loopd = 8'h33, pat = 8'hC2;
	logic [7:0] det, od, msk, rd_v, gd, gm, gdt;
	logic [3:0] osig, gs;
	logic [7:0] st [4] = '{8'h3C, 8'h11, 8'h22, 8'h33};
	logic [23:0] rw [4] = '{24'h19FF00, 24'h58FF7F, 24'h38A5A5, 24'h18C3C3};
	logic [23:0] gt [6] = '{24'h180100, 24'h1802FE, 24'h180300, 24'h1800FF, 24'h1001FF, 24'h0801FF};
	logic [23:0] sg [3] = '{24'h3A001A, 24'h0A0005, 24'h0A400A};
	logic [31:0] pt [7] = '{32'h005B0000, 32'h025B0000, 32'h04C20000, 32'h08C30000, 32'h065B015B,
		32'h0A5B015A, 32'h0C5B0000};
	int mismatches = 0, tests_run = 0, cyc_n = 0, i, n;

	tpc_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .in_valid_i(inv),
		.in_item_i(item), .in_ready_o(inr), .alaw_mw_i(alaw), .mulaw_mw_i(mulaw), .loop_data_i(loopd),
		.pat_gen_i(pat), .pat_take_o(take), .pat_det_o(det), .pat_det_valid_o(detv), .pat_det_7bit_o(d7),
		.out_valid_o(ov), .out_data_o(od), .out_sig_o(osig), .out_sig_ins_o(ins), .out_clk_mask_o(msk),
		.out_ready_i(ordy));
	tpc_bp bp (.clk_i(clk_i), .rst_i(rst_i), .valid_o(inv), .item_o(item), .ready_i(inr));

	// ------------------------------------------------------------
	// Harness tasks.
	// ------------------------------------------------------------
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// The pattern source steps only when a byte is consumed, so gaps in its sequence show up as wrong data.
	always @(posedge clk_i) begin
		cyc_n++;
		if (take === 1'b1) pat <= pat + 8'h01;
		if (cyc_n == 20000) begin
			mismatches++;
			results();
		end
	end
	task results;
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One classic cycle; the request is held until ack is sampled high.
	task wb(input logic w, input logic [6:0] idx, input logic [7:0] d);
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		chk("ack", 1, ack);
		rd_v = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task rx;
		n = 0;
		@(posedge clk_i);
		while (ov !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		chk("out valid", 1, ov);
		gd = od;
		gs = osig;
		gi = ins;
		gm = msk;
		gv = detv;
		gdt = det;
	endtask : rx
	task oct(input logic [4:0] c, input logic [7:0] d, input logic [3:0] s);
		bp.q.push_back('{c, d, s});
		rx();
	endtask : oct

	// ------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rw[k]) begin
			wb(0, rw[k][22:16], 8'h00);
			chk("reset value", 0, rd_v);
			wb(1, rw[k][22:16], rw[k][15:8]);
			wb(0, rw[k][22:16], 8'h00);
			chk("readback", rw[k][7:0], rd_v);
		end
		for (i = 0; i < 8; i++) begin
			wb(1, CTRL_BASE, 8'(i << 2));
			oct(5'd0, 8'hA5, 4'h0);
			chk("inverted", 8'hA5 ^ ({8{i[2]}} & 8'h80 | {8{i[1]}} & 8'h2A | {8{i[0]}} & 8'h55), gd);
		end
		oct(5'd1, 8'hA5, 4'h0);
		chk("other channel", 8'hA5, gd);
		foreach (gt[k]) begin
			wb(1, GCFG_IDX, gt[k][23:16]);
			wb(1, CTRL_BASE + 7'h01, gt[k][15:8]);
			oct(5'd1, 8'h0F, 4'h0);
			chk("clock mask", gt[k][7:0], gm);
		end
		wb(1, GCFG_IDX, 8'h00);
		wb(1, DATA_TRUNK_CODE_BASE + 7'h02, 8'h3C);
		for (i = 1; i < 5; i++) begin
			wb(1, CTRL_BASE + 7'h02, 8'(i << 5));
			oct(5'd2, 8'hA5, 4'h0);
			chk("substituted", st[i-1], gd);
		end
		wb(1, GCFG_IDX, 8'h01);
		oct(5'd2, 8'hA5, 4'h0);
		chk("global trunk", 8'h3C, gd);
		foreach (sg[k]) begin
			wb(1, STRK_BASE + 7'h03, sg[k][23:16]);
			wb(1, GCFG_IDX, sg[k][15:8]);
			oct(5'd3, 8'h00, 4'h5);
			chk("signaling", sg[k][7:0], {3'b000, gi, gs});
		end
		wb(1, GCFG_IDX, 8'h00);
		wb(1, STRK_BASE + 7'h04, 8'h40);
		foreach (pt[k]) begin
			wb(1, PCFG_IDX, pt[k][31:24]);
			oct(5'd4, 8'h5B, 4'h0);
			chk("pattern data", pt[k][23:16], gd);
			chk("detector", pt[k][15:0], {7'h00, gv, gv ? gdt : 8'h00});
			chk("detector 7bit", pt[k][8] & pt[k][27], gv & d7);
		end
		wb(1, STRK_BASE + 7'h05, 8'h40);
		wb(1, PCFG_IDX, 8'h04);
		bp.q.push_back('{5'd4, 8'h00, 4'h0});
		bp.q.push_back('{5'd6, 8'h77, 4'h0});
		bp.q.push_back('{5'd5, 8'h00, 4'h0});
		rx();
		chk("stream", 8'hC4, gd);
		rx();
		chk("stream", 8'h77, gd);
		rx();
		chk("stream", 8'hC5, gd);
		wb(1, PCFG_IDX, 8'h00);
		ordy <= 1'b0;
		for (i = 0; i < 6; i++) bp.q.push_back('{5'd5, 8'(i), 4'h0});
		repeat (12) @(posedge clk_i);
		chk("in ready full", 0, inr);
		ordy <= 1'b1;
		for (i = 0; i < 6; i++) begin
			rx();
			chk("fifo order", i, gd);
		end
		results();
	end
endmodule : tb_tpc_core

// File: tpc_bp.sv
// Backplane model that feeds channel octets into the conditioning block.
// Assumes the bench queues items and that ready from the block is a level.
module tpc_bp
	import tpc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Channel stream toward the block.
	output logic valid_o = 1'b0,
	output tpc_item_t item_o = '0,
	input wire logic ready_i
);
	timeunit 1ns;
	timeprecision 1ns;
	tpc_item_t q[$];
	// Each octet is held until taken; an idle bus toggles so stale data is never mistaken for valid.
	always @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
		end else if (!valid_o || ready_i) begin
			if (q.size() > 0) begin
				valid_o <= 1'b1;
				item_o <= q.pop_front();
			end else begin
				valid_o <= 1'b0;
				item_o <= ~item_o;
			end
		end
	end
endmodule : tpc_bp

// File: tpc_core.sv
// Transmit payload conditioning: buffer, per-channel registers, datapath.
// Assumes inputs synchronous to clk_i and a classic Wishbone master.

// ------------------------------------------------------------
// Parameterised buffer.
// ------------------------------------------------------------
module tpc_fifo #(
	parameter int W = 17,
	parameter int D = 4
) (
	// Clock and control.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Fill side.
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side.
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(D);
	localparam logic [AW-1:0] TOP = AW'(D - 1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] cnt;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
	} tpc_fifo_st_t;
	tpc_fifo_st_t s_r, s_nxt;
	logic push, pop;

	// Honest flags; the drain side may stall so the buffer really fills.
	assign in_ready_o = s_r.cnt != FULL;
	assign out_valid_o = s_r.cnt != '0;
	assign out_data_o = s_r.mem[s_r.rp];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Pointer and count update.
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = (s_r.wp == TOP) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == TOP) ? '0 : s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end
endmodule : tpc_fifo

// ------------------------------------------------------------
// Top level.
// ------------------------------------------------------------
module tpc_core
	import tpc_pkg::*;
(
	// Clock, reset, enable.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Backplane channel stream in.
	input wire logic in_valid_i,
	input wire tpc_item_t in_item_i,
	output logic in_ready_o,
	// Side sources for substitution.
	input wire logic [7:0] alaw_mw_i,
	input wire logic [7:0] mulaw_mw_i,
	input wire logic [7:0] loop_data_i,
	// Pattern generator and detector.
	input wire logic [7:0] pat_gen_i,
	output logic pat_take_o,
	output logic [7:0] pat_det_o,
	output logic pat_det_valid_o,
	output logic pat_det_7bit_o,
	// Line-side stream out.
	output logic out_valid_o,
	output logic [7:0] out_data_o,
	output logic [3:0] out_sig_o,
	output logic out_sig_ins_o,
	output logic [7:0] out_clk_mask_o,
	input wire logic out_ready_i
);
	typedef struct packed {
		logic [NUM_CH-1:0][7:0] ctrl;
		logic [NUM_CH-1:0][7:0] data_trunk_code;
		logic [NUM_CH-1:0][6:0] strk;
		logic [7:0] gcfg;
		logic [7:0] pcfg;
		logic ack;
		logic [31:0] rdat;
		logic ov;
		logic [7:0] od;
		logic [3:0] os;
		logic oins;
		logic [7:0] ogap;
		logic [7:0] det;
		logic dv;
		logic d7;
		logic [4:0] last;
	} tpc_state_t;
	tpc_state_t s_r, s_nxt;
	tpc_item_t f_item;
	logic f_valid, f_ready, fire;

	// Maps a register index onto a channel within one range.
	function automatic logic [5:0] ch_hit(input logic [6:0] idx, input logic [6:0] base);
		logic [6:0] d;
		d = idx - base;
		ch_hit = {(idx >= base) && (d < 7'(NUM_CH)), d[4:0]};
	endfunction : ch_hit

	// ------------------------------------------------------------
	// Input buffer.
	// ------------------------------------------------------------
	tpc_fifo #(
		.W($bits(tpc_item_t)),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.in_valid_i(in_valid_i),
		.in_data_i(in_item_i),
		.in_ready_o(in_ready_o),
		.out_valid_o(f_valid),
		.out_data_o(f_item),
		.out_ready_i(f_ready)
	);

	// The output slot frees when empty or taken this cycle.
	assign f_ready = !s_r.ov || out_ready_i;
	assign fire = f_valid && f_ready;

	// ------------------------------------------------------------
	// Conditioning datapath and register file.
	// ------------------------------------------------------------
	logic [6:0] idx;
	logic [5:0] hc, hd, hs;
	logic [7:0] cc, st, dat, mask;
	logic [2:0] sub;
	logic okch, test_on;
	always_comb begin
		s_nxt = s_r;
		idx = wb_adr_i[8:2];
		hc = ch_hit(idx, CTRL_BASE);
		hd = ch_hit(idx, DATA_TRUNK_CODE_BASE);
		hs = ch_hit(idx, STRK_BASE);
		okch = f_item.chan <= LAST_CH;
		cc = okch ? s_r.ctrl[f_item.chan] : RST_BYTE;
		st = okch ? {1'b0, s_r.strk[f_item.chan]} : RST_BYTE;
		sub = (s_r.gcfg[2:0] != SUB_NONE) ? s_r.gcfg[2:0] : cc[7:CC_SUB_LSB];
		dat = f_item.data;
		case (sub)
			SUB_TRUNK: dat = okch ? s_r.data_trunk_code[f_item.chan] : f_item.data;
			SUB_ALAW: dat = alaw_mw_i;
			SUB_MULAW: dat = mulaw_mw_i;
			SUB_LOOP: dat = loop_data_i;
			default: dat = f_item.data;
		endcase
		test_on = st[ST_TEST] && (s_r.pcfg[3:2] == PM_8BIT || s_r.pcfg[3:2] == PM_7BIT);
		if (test_on && !s_r.pcfg[PC_DIR]) begin
			// Generated pattern overwrites the channel, 7 MSB only in 7-bit mode.
			if (s_r.pcfg[3:2] == PM_7BIT) begin
				dat = (pat_gen_i & MASK_7MSB) | (dat & ~MASK_7MSB);
			end else begin
				dat = pat_gen_i;
			end
		end
		mask = (cc[CC_INVERT_MSB_SEL] ? INV_MSB : RST_BYTE)
			| (cc[CC_INVERT_ODD_SEL] ? INV_ODD : RST_BYTE)
			| (cc[CC_INVERT_EVEN_SEL] ? INV_EVEN : RST_BYTE);
		// Bus: ack one cycle after the strobe, dropped the cycle after.
		s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
		s_nxt.rdat = '0;
		if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
			if (wb_we_i && wb_sel_i[0]) begin
				if (hc[5]) s_nxt.ctrl[hc[4:0]] = wb_dat_i[7:0];
				if (hd[5]) s_nxt.data_trunk_code[hd[4:0]] = wb_dat_i[7:0];
				if (hs[5]) s_nxt.strk[hs[4:0]] = wb_dat_i[6:0];
				if (idx == GCFG_IDX) s_nxt.gcfg = wb_dat_i[7:0];
				if (idx == PCFG_IDX) s_nxt.pcfg = wb_dat_i[7:0];
			end
			if (hc[5]) s_nxt.rdat[7:0] = s_r.ctrl[hc[4:0]];
			if (hd[5]) s_nxt.rdat[7:0] = s_r.data_trunk_code[hd[4:0]];
			if (hs[5]) s_nxt.rdat[6:0] = s_r.strk[hs[4:0]];
			if (idx == GCFG_IDX) s_nxt.rdat[7:0] = s_r.gcfg;
			if (idx == PCFG_IDX) s_nxt.rdat[7:0] = s_r.pcfg;
			if (idx == STAT_IDX) s_nxt.rdat[7:0] = {s_r.ov, f_valid, in_ready_o, s_r.last};
		end
		// Output slot.
		s_nxt.dv = 1'b0;
		if (s_r.ov && out_ready_i) s_nxt.ov = 1'b0;
		if (fire) begin
			s_nxt.ov = 1'b1;
			s_nxt.last = f_item.chan;
			s_nxt.od = dat ^ mask;
			s_nxt.oins = st[ST_INS];
			s_nxt.os = (st[ST_TRK] || s_r.gcfg[GC_GTRK]) ? st[3:0] : f_item.sig;
			s_nxt.ogap = GAP_NONE;
			if (s_r.gcfg[GC_MST] && s_r.gcfg[GC_CCE]) begin
				if (cc[CC_GAP]) s_nxt.ogap = GAP_ALL;
				else if (cc[CC_G56]) s_nxt.ogap = GAP_LSB;
			end
			if (test_on && s_r.pcfg[PC_DIR]) begin
				s_nxt.dv = 1'b1;
				s_nxt.d7 = s_r.pcfg[3:2] == PM_7BIT;
				s_nxt.det = (s_r.pcfg[3:2] == PM_7BIT) ? (f_item.data & MASK_7MSB) : f_item.data;
			end
		end
	end

	// Replacing channels draw consecutive pattern octets, one per slot.
	assign pat_take_o = ce_i && fire && test_on && !s_r.pcfg[PC_DIR];

	// State register; clock enable freezes everything.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.rdat;
	assign out_valid_o = s_r.ov;
	assign out_data_o = s_r.od;
	assign out_sig_o = s_r.os;
	assign out_sig_ins_o = s_r.oins;
	assign out_clk_mask_o = s_r.ogap;
	assign pat_det_o = s_r.det;
	assign pat_det_valid_o = s_r.dv;
	assign pat_det_7bit_o = s_r.d7;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence bus_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	endsequence
	sequence bus_ack_s;
		wb_ack_o ##1 (!wb_ack_o || !ce_i);
	endsequence
	bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
		else $error("bus ack not given then dropped");
	plain_pass_a: assert property (fire && ce_i && cc[4:2] == 3'h0 && sub == SUB_NONE && !test_on
		|=> out_data_o == $past(f_item.data))
		else $error("channel not passed unchanged");
	inv_even_a: assert property (fire && ce_i && cc[4:2] == 3'h1 && sub == SUB_NONE && !test_on
		|=> (out_data_o ^ $past(f_item.data)) == INV_EVEN)
		else $error("even inversion wrong");
	trunk_sub_a: assert property (fire && ce_i && okch && sub == SUB_TRUNK && cc[4:2] == 3'h0 && !test_on
		|=> out_data_o == $past(s_r.data_trunk_code[f_item.chan]))
		else $error("trunk code not substituted");
	gap_gate_a: assert property (fire && ce_i && !(s_r.gcfg[GC_MST] && s_r.gcfg[GC_CCE])
		|=> out_clk_mask_o == GAP_NONE)
		else $error("gap applied while not allowed");
	gap_slot_a: assert property (fire && ce_i && s_r.gcfg[GC_MST] && s_r.gcfg[GC_CCE] && cc[CC_GAP]
		|=> out_clk_mask_o == GAP_ALL)
		else $error("channel gap missing");
	sig_ins_a: assert property (fire && ce_i |=> out_sig_ins_o == $past(st[ST_INS]))
		else $error("signaling insert flag wrong");
	sig_trunk_a: assert property (fire && ce_i && s_r.gcfg[GC_GTRK] |=> out_sig_o == $past(st[3:0]))
		else $error("global signaling trunk not applied");
	pat_take_a: assert property (pat_take_o |-> s_r.pcfg[3:2] == PM_8BIT || s_r.pcfg[3:2] == PM_7BIT)
		else $error("pattern taken outside test mode");
	reset_clear_a: assert property ($past(rst_i) |-> s_r.data_trunk_code == '0 && s_r.strk == '0)
		else $error("channel registers not cleared");
endmodule : tpc_core

// File: tpc_pkg.sv
// Constants and carrier types for the transmit payload conditioning block.
// Assumes one clock domain and register access over classic Wishbone.
package tpc_pkg;
	// ------------------------------------------------------------
	// Register indices; the byte address is four times the index.
	// ------------------------------------------------------------
	localparam logic [6:0] CTRL_BASE = 7'h01;
	localparam logic [6:0] DATA_TRUNK_CODE_BASE = 7'h21;
	localparam logic [6:0] STRK_BASE = 7'h41;
	localparam logic [6:0] GCFG_IDX = 7'h60;
	localparam logic [6:0] PCFG_IDX = 7'h61;
	localparam logic [6:0] STAT_IDX = 7'h62;
	localparam int NUM_CH = 24;
	localparam logic [4:0] LAST_CH = 5'h17;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] RST_STRK = 7'h00;
	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int CC_SUB_LSB = 5;
	localparam int CC_INVERT_MSB_SEL = 4;
	localparam int CC_INVERT_ODD_SEL = 3;
	localparam int CC_INVERT_EVEN_SEL = 2;
	localparam int CC_G56 = 1;
	localparam int CC_GAP = 0;
	localparam int ST_TEST = 6;
	localparam int ST_INS = 5;
	localparam int ST_TRK = 4;
	localparam int GC_CCE = 3;
	localparam int GC_MST = 4;
	localparam int GC_GTRK = 6;
	localparam int PC_DIR = 1;
	localparam int PC_MODE_LSB = 2;
	// ------------------------------------------------------------
	// Codes and masks.
	// ------------------------------------------------------------
	localparam logic [2:0] SUB_NONE = 3'h0;
	localparam logic [2:0] SUB_TRUNK = 3'h1;
	localparam logic [2:0] SUB_ALAW = 3'h2;
	localparam logic [2:0] SUB_MULAW = 3'h3;
	localparam logic [2:0] SUB_LOOP = 3'h4;
	localparam logic [1:0] PM_8BIT = 2'h1;
	localparam logic [1:0] PM_7BIT = 2'h2;
	localparam logic [7:0] INV_MSB = 8'h80;
	localparam logic [7:0] INV_ODD = 8'h2A;
	localparam logic [7:0] INV_EVEN = 8'h55;
	localparam logic [7:0] GAP_NONE = 8'hFF;
	localparam logic [7:0] GAP_LSB = 8'hFE;
	localparam logic [7:0] GAP_ALL = 8'h00;
	localparam logic [7:0] MASK_7MSB = 8'hFE;
	// ------------------------------------------------------------
	// One channel octet as it travels through the buffer.
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0] chan;
		logic [7:0] data;
		logic [3:0] sig;
	} tpc_item_t;
endpackage : tpc_pkg
